// ---- rtl/thermal_derate_pkg.sv ----
// thermal de-rating configuration: shared constants and types
// assumes one 40 MHz clock and a synchronous active-low reset
package thermal_derate_pkg;

    // ----------------------------------------------------------------
    // bus and register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] NTC_LIMIT_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] DERATE_CONFIG_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
    localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 4'hc;
    localparam logic [7:0] NTC_LIMIT_RESET = 8'h00;
    localparam logic [7:0] DERATE_CONFIG_RESET = 8'h00;
    localparam logic [7:0] STEP_COUNT_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int UPPER_LSB = 4;
    localparam int LOWER_LSB = 0;
    localparam int DIE_LSB = 6;
    localparam int INTERVAL_LSB = 1;
    localparam int COMP_EN_BIT = 0;

    // ----------------------------------------------------------------
    // die threshold codes, in degrees celsius
    // ----------------------------------------------------------------
    localparam logic [1:0] DIE_OFF = 2'h0;
    localparam logic [7:0] DIE_T1_C = 8'h5a; // 90
    localparam logic [7:0] DIE_T2_C = 8'h64; // 100
    localparam logic [7:0] DIE_T3_C = 8'h6e; // 110

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 40000000;
    localparam longint STEP_UNIT_S = 2;
    localparam longint STEP_UNIT_CYCLES = STEP_UNIT_S * CLK_HZ;

    typedef enum logic [1:0] {
        LIM_IDLE = 2'b00,
        LIM_REDUCE = 2'b01,
        LIM_HOLD = 2'b10
    } lim_state_t;

endpackage : thermal_derate_pkg

// ---- rtl/ntc_level_table.sv ----
// ntc resistance table: sixteen fixed points in units of 10 ohm
// assumes a purely combinational lookup
`timescale 1ns/10ps
`default_nettype none
module ntc_level_table (
    input wire logic [3:0] code,
    output logic [13:0] res_10ohm
);
    // monotone from 79.67 kohm at code 0 down to 5.87 kohm at code 15
    always_comb begin
        case (code)
            4'h0: res_10ohm = 14'd7967;
            4'h1: res_10ohm = 14'd4335;
            4'h2: res_10ohm = 14'd2977;
            4'h3: res_10ohm = 14'd2267;
            4'h4: res_10ohm = 14'd1830;
            4'h5: res_10ohm = 14'd1534;
            4'h6: res_10ohm = 14'd1321;
            4'h7: res_10ohm = 14'd1160;
            4'h8: res_10ohm = 14'd1034;
            4'h9: res_10ohm = 14'd932;
            4'ha: res_10ohm = 14'd849;
            4'hb: res_10ohm = 14'd779;
            4'hc: res_10ohm = 14'd720;
            4'hd: res_10ohm = 14'd669;
            4'he: res_10ohm = 14'd625;
            default: res_10ohm = 14'd587;
        endcase
    end
endmodule : ntc_level_table
`default_nettype wire

// ---- rtl/thermal_derate.sv ----
// thermal de-rating: ntc limit compare, step limiter, die threshold
// assumes an axi4-lite master and an adc delivering the ntc resistance
`timescale 1ns/10ps
`default_nettype none
module thermal_derate
    import thermal_derate_pkg::*;
#(
    parameter longint STEP_UNIT = STEP_UNIT_CYCLES,
    parameter int STEP_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic io_supply_enable_pin,
    input wire logic pwm_in,
    input wire logic [13:0] ntc_res_10ohm,
    input wire logic [7:0] die_temp_c,
    output logic pwm_out,
    output logic die_derate_active,
    output logic [STEP_W-1:0] ntc_step_count
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] ntc_limit_thresholds_reg, ntc_limit_thresholds_next;
    logic [7:0] thermal_derate_config_reg, thermal_derate_config_next;
    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic step_clear_req;

    // field views
    logic [3:0] ntc_upper_limit_code;
    logic [3:0] ntc_lower_limit_code;
    logic [1:0] die_derate_threshold;
    logic [4:0] ntc_step_interval;
    logic ntc_compensation_on;

    assign ntc_upper_limit_code = ntc_limit_thresholds_reg[UPPER_LSB +: 4];
    assign ntc_lower_limit_code = ntc_limit_thresholds_reg[LOWER_LSB +: 4];
    assign die_derate_threshold = thermal_derate_config_reg[DIE_LSB +: 2];
    assign ntc_step_interval = thermal_derate_config_reg[INTERVAL_LSB +: 5];
    assign ntc_compensation_on = thermal_derate_config_reg[COMP_EN_BIT];

    // decode a word-aligned register index
    function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[3:2];
    endfunction : reg_index

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    logic do_write;
    logic [7:0] wbyte;
    logic [7:0] status_byte;

    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wbyte = w_data_reg[7:0];

    // write/read channel next state
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        ntc_limit_thresholds_next = ntc_limit_thresholds_reg;
        thermal_derate_config_next = thermal_derate_config_reg;
        step_clear_req = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (reg_index(aw_addr_reg))
                reg_index(NTC_LIMIT_OFFSET): begin
                    if (w_strb_reg[0]) ntc_limit_thresholds_next = wbyte;
                end
                reg_index(DERATE_CONFIG_OFFSET): begin
                    if (w_strb_reg[0]) thermal_derate_config_next = wbyte;
                end
                reg_index(CONTROL_OFFSET): begin
                    step_clear_req = w_strb_reg[0] && wbyte[0]; // restore full current
                end
                default: bresp_next = RESP_SLVERR; // status is read-only
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (reg_index(s_axi_araddr))
                reg_index(NTC_LIMIT_OFFSET): rdata_next = {24'h0, ntc_limit_thresholds_reg};
                reg_index(DERATE_CONFIG_OFFSET): rdata_next = {24'h0, thermal_derate_config_reg};
                reg_index(STATUS_OFFSET): rdata_next = {24'h0, status_byte};
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = RESP_OKAY; // control reads as zero
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
            ntc_limit_thresholds_reg <= NTC_LIMIT_RESET;
            thermal_derate_config_reg <= DERATE_CONFIG_RESET;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            ntc_limit_thresholds_reg <= ntc_limit_thresholds_next;
            thermal_derate_config_reg <= thermal_derate_config_next;
        end
    end

    // ----------------------------------------------------------------
    // ntc limit lookup
    // ----------------------------------------------------------------
    logic [13:0] upper_res;
    logic [13:0] lower_res;

    ntc_level_table upper_table (
        .code(ntc_upper_limit_code),
        .res_10ohm(upper_res)
    );

    ntc_level_table lower_table (
        .code(ntc_lower_limit_code),
        .res_10ohm(lower_res)
    );

    // ----------------------------------------------------------------
    // ntc step limiter
    // ----------------------------------------------------------------
    localparam int TICK_W = 40;
    lim_state_t state_reg, state_next;
    logic [TICK_W-1:0] tick_reg, tick_next;
    logic [4:0] unit_reg, unit_next;
    logic [STEP_W-1:0] step_reg, step_next;
    logic below_upper;
    logic above_lower;
    logic interval_done;

    assign below_upper = ntc_res_10ohm < upper_res; // hot side
    assign above_lower = ntc_res_10ohm > lower_res; // cooled down
    assign interval_done = (tick_reg == TICK_W'(STEP_UNIT - 1)) && (unit_reg == ntc_step_interval);

    // limiter next state: steps every (code + 1) * 2 s while hot
    always_comb begin
        state_next = state_reg;
        tick_next = tick_reg;
        unit_next = unit_reg;
        step_next = step_reg;
        case (state_reg)
            LIM_IDLE: begin
                tick_next = '0;
                unit_next = 5'h0;
                if (ntc_compensation_on && below_upper) state_next = LIM_REDUCE;
            end
            LIM_REDUCE: begin
                if (tick_reg == TICK_W'(STEP_UNIT - 1)) begin
                    tick_next = '0;
                    unit_next = unit_reg + 5'h1;
                end else begin
                    tick_next = tick_reg + TICK_W'(1);
                end
                if (interval_done) begin
                    unit_next = 5'h0;
                    if (step_reg != {STEP_W{1'b1}}) step_next = step_reg + STEP_W'(1);
                end
                if (above_lower) state_next = LIM_HOLD;
            end
            LIM_HOLD: begin
                tick_next = '0;
                unit_next = 5'h0;
                if (below_upper) state_next = LIM_REDUCE;
            end
            default: state_next = LIM_IDLE;
        endcase
        if (!ntc_compensation_on) begin
            state_next = LIM_IDLE;
            step_next = STEP_W'(STEP_COUNT_RESET);
        end
        if (step_clear_req) step_next = STEP_W'(STEP_COUNT_RESET);
    end

    // limiter registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= LIM_IDLE;
            tick_reg <= '0;
            unit_reg <= 5'h0;
            step_reg <= STEP_W'(STEP_COUNT_RESET);
        end else begin
            state_reg <= state_next;
            tick_reg <= tick_next;
            unit_reg <= unit_next;
            step_reg <= step_next;
        end
    end

    // ----------------------------------------------------------------
    // die threshold and outputs
    // ----------------------------------------------------------------
    logic [7:0] die_limit_c;
    logic die_active_next, die_active_reg;
    logic pwm_next, pwm_reg;

    // threshold decode
    always_comb begin
        case (die_derate_threshold)
            2'h1: die_limit_c = DIE_T1_C;
            2'h2: die_limit_c = DIE_T2_C;
            default: die_limit_c = DIE_T3_C;
        endcase
        die_active_next = (die_derate_threshold != DIE_OFF) && (die_temp_c >= die_limit_c);
        pwm_next = io_supply_enable_pin && pwm_in;
    end

    // output registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            die_active_reg <= 1'b0;
            pwm_reg <= 1'b0;
        end else begin
            die_active_reg <= die_active_next;
            pwm_reg <= pwm_next;
        end
    end

    assign die_derate_active = die_active_reg;
    assign pwm_out = pwm_reg;
    assign ntc_step_count = step_reg;
    assign status_byte = {die_active_reg, 1'b0, state_reg, step_reg[3:0]};

endmodule : thermal_derate
`default_nettype wire

// ---- bench/ntc_sensor_model.sv ----
// thermistor and die sensor stand-in for the readout block
// assumes the bench sets target readings just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module ntc_sensor_model (
    input wire logic aclk,
    input wire logic [13:0] res_set,
    input wire logic [7:0] die_set,
    output logic [13:0] ntc_res_10ohm,
    output logic [7:0] die_temp_c
);
    // one sample of converter delay on both readings
    always_ff @(posedge aclk) begin
        ntc_res_10ohm <= res_set;
        die_temp_c <= die_set;
    end
endmodule : ntc_sensor_model
`default_nettype wire

// ---- bench/thermal_derate_chk.sv ----
// checker: bus answer timing, pwm path, die flag and step limiter
// assumes it is bound into thermal_derate with the design's STEP_UNIT
`timescale 1ns/10ps
`default_nettype none
module thermal_derate_chk
    import thermal_derate_pkg::*;
#(
    parameter longint STEP_UNIT = STEP_UNIT_CYCLES,
    parameter int STEP_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic io_supply_enable_pin,
    input wire logic pwm_in,
    input wire logic [13:0] ntc_res_10ohm,
    input wire logic pwm_out,
    input wire logic [7:0] die_temp_c,
    input wire logic die_derate_active,
    input wire logic [STEP_W-1:0] ntc_step_count
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [STEP_W-1:0] prev_cnt;
    logic inc;
    longint gap;
    // ----------------------------------------------------------------
    // helper: cycles since the last count increment
    // ----------------------------------------------------------------
    assign inc = (ntc_step_count == prev_cnt + 1'b1);
    always_ff @(posedge aclk) begin
        prev_cnt <= ntc_step_count;
        if (!aresetn) gap <= 0;
        else if (inc) gap <= 1;
        else gap <= gap + 1;
    end
    // ----------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_cool2;
        (ntc_res_10ohm > 14'd7967) [*2];
    endsequence
    property p_pwm;
        $past(aresetn) |-> pwm_out == $past(pwm_in & io_supply_enable_pin);
    endproperty
    property p_die_floor;
        die_derate_active |-> $past(die_temp_c) >= DIE_T1_C;
    endproperty
    property p_cnt_step;
        $changed(ntc_step_count) && ntc_step_count != 0 |-> inc;
    endproperty
    property p_cnt_gap;
        inc |-> gap >= STEP_UNIT;
    endproperty
    property p_cnt_cool;
        s_cool2 |=> ntc_step_count <= $past(ntc_step_count);
    endproperty
    property p_read_lat;
        s_ar_take |=> s_axi_rvalid;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rdata_hi;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm_out wrong");
    a_die_floor: assert property (p_die_floor) else $error("die flag too early");
    a_cnt_step: assert property (p_cnt_step) else $error("count jumped");
    a_cnt_gap: assert property (p_cnt_gap) else $error("steps too close");
    a_cnt_cool: assert property (p_cnt_cool) else $error("count rose when cool");
    a_read_lat: assert property (p_read_lat) else $error("read answer late");
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
endmodule : thermal_derate_chk
`default_nettype wire

// ---- bench/thermal_derate_tb_top.sv ----
// testbench top: bus master tasks, row table and limiter scenarios
// assumes STEP_UNIT of 4 cycles so one step interval is (code+1)*4
`timescale 1ns/10ps
`default_nettype none
module thermal_derate_tb_top
    import thermal_derate_pkg::*;
;
    typedef struct {logic [3:0] a; logic [7:0] d; logic [1:0] wr; logic [7:0] rv;} row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, io_supply_enable_pin, pwm_in, pwm_out, die_derate_active;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [13:0] ntc_res_10ohm, res_set;
    logic [7:0] die_temp_c, die_set, ntc_step_count;
    logic [7:0] thr [4] = '{8'hff, DIE_T1_C, DIE_T2_C, DIE_T3_C};
    row_t rows [4] = '{'{NTC_LIMIT_OFFSET, 8'ha5, RESP_OKAY, 8'ha5},
        '{DERATE_CONFIG_OFFSET, 8'hfe, RESP_OKAY, 8'hfe},
        '{STATUS_OFFSET, 8'hff, RESP_SLVERR, 8'h00},
        '{CONTROL_OFFSET, 8'h01, RESP_OKAY, 8'h00}};
    int err_total, n_checks, k, m;
    // clock and design instances
    always #12.5 aclk = ~aclk;
    thermal_derate #(.STEP_UNIT(4)) i_dut (.*);
    ntc_sensor_model i_ntc (.aclk(aclk), .res_set(res_set), .die_set(die_set),
        .ntc_res_10ohm(ntc_res_10ohm), .die_temp_c(die_temp_c));
    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic hang();
        err_total++;
        $display("mismatch bus wait expected answer seen none");
        final_report();
    endtask : hang
    task automatic done_test(input string s);
        $display("test %s done", s);
    endtask : done_test
    task automatic cntchk(input logic [7:0] e);
        chk("ntc_step_count", {24'h0, ntc_step_count}, {24'h0, e});
    endtask : cntchk
    // ----------------------------------------------------------------
    // axi4-lite master: answer readies held high from the request until valid
    // ----------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] v, output logic [1:0] rs);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (i == 40) hang();
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (i == 40) hang();
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic wcfg(input logic [3:0] a, input logic [7:0] v);
        logic [1:0] rs;
        wr(a, v, rs);
        chk("write resp", {30'h0, rs}, {30'h0, RESP_OKAY});
    endtask : wcfg
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, io_supply_enable_pin, pwm_in} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        res_set = 14'd8000;
        die_set = 8'd25;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // pwm pass-through with no bus traffic at all
        for (k = 0; k < 4; k++) begin
            io_supply_enable_pin <= k[1];
            pwm_in <= k[0];
            repeat (2) @(posedge aclk);
            chk("pwm_out", {31'h0, pwm_out}, {31'h0, k[1] & k[0]});
        end
        done_test("standalone");
        rd(NTC_LIMIT_OFFSET, d, r);
        chk("limit reset", d, {24'h0, NTC_LIMIT_RESET});
        rd(DERATE_CONFIG_OFFSET, d, r);
        chk("config reset", d, {24'h0, DERATE_CONFIG_RESET});
        done_test("reset");
        // register rows: write response, then read back
        foreach (rows[j]) begin
            wr(rows[j].a, rows[j].d, r);
            chk("write resp", {30'h0, r}, {30'h0, rows[j].wr});
            rd(rows[j].a, d, r);
            chk("read data", d, {24'h0, rows[j].rv});
            chk("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
        end
        done_test("rows");
        // each die threshold code, one degree below and at the threshold
        for (k = 0; k < 4; k++) begin
            wcfg(DERATE_CONFIG_OFFSET, {k[1:0], 6'h0});
            for (m = 0; m < 2; m++) begin
                die_set <= thr[k] - 8'd1 + m[7:0];
                repeat (4) @(posedge aclk);
                chk("die flag", {31'h0, die_derate_active}, {31'h0, k != 0 && m == 1});
            end
        end
        done_test("die");
        // limiter just past both limits of codes 1 and 0, interval 8 cycles
        res_set <= 14'd4334;
        wcfg(NTC_LIMIT_OFFSET, 8'h10);
        wcfg(DERATE_CONFIG_OFFSET, 8'h03);
        repeat (20) @(posedge aclk);
        cntchk(8'd2);
        res_set <= 14'd7968;
        repeat (20) @(posedge aclk);
        cntchk(8'd2);
        wcfg(DERATE_CONFIG_OFFSET, 8'h02);
        res_set <= 14'd4334;
        repeat (20) @(posedge aclk);
        cntchk(8'd0);
        done_test("limiter");
        // code f limits at the exact point, interval 4 cycles
        wcfg(NTC_LIMIT_OFFSET, 8'hff);
        res_set <= 14'd587;
        wcfg(DERATE_CONFIG_OFFSET, 8'h01);
        repeat (12) @(posedge aclk);
        cntchk(8'd0);
        res_set <= 14'd586;
        repeat (12) @(posedge aclk);
        cntchk(8'd2);
        done_test("limit edge");
        // the clear command zeroes the count while the limiter keeps reducing
        wcfg(CONTROL_OFFSET, 8'h01);
        cntchk(8'h00);
        rd(STATUS_OFFSET, d, r);
        chk("status", d, 32'h10);
        done_test("clear");
        // mid-run reset puts the registers and the limiter back to rest
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        cntchk(8'h00);
        rd(DERATE_CONFIG_OFFSET, d, r);
        chk("config after reset", d, {24'h0, DERATE_CONFIG_RESET});
        done_test("mid reset");
        final_report();
    end
endmodule : thermal_derate_tb_top
bind thermal_derate thermal_derate_chk #(.STEP_UNIT(STEP_UNIT), .STEP_W(STEP_W)) i_chk (.*);
`default_nettype wire
